// ===== rtl/wcseq_top.sv
// Weld cycle sequencer: null wait through retract, with its register port
`timescale 1ns/10ps
`default_nettype none
`include "wcseq_map.svh"

module wcseq_top
    import wcseq_pkg::*;
#(
    parameter int TICK_CYCLES = `WCS_TICK_CYCLES   // Clock cycles per second tick
) (
    // Clock and reset
    input  wire logic                   CLK_IN,
    input  wire logic                   RST_IN,
    // Register port
    input  wire logic [`WCS_ADDR_W-1:0] ADDR_IN,
    input  wire logic [`WCS_DATA_W-1:0] WR_DATA_IN,
    input  wire logic                   WR_IN,
    input  wire logic                   RD_IN,
    output logic      [`WCS_DATA_W-1:0] RD_DATA_OUT,
    // Pendant and remote inputs
    input  wire logic                   START_IN,
    input  wire logic                   AUTO_IN,
    input  wire logic                   SIDETRACK_SEL_IN,
    input  wire logic                   ALL_NULL_IN,
    input  wire logic                   TACK_IN,
    input  wire logic                   TACK_DISABLE_IN,
    input  wire logic                   CUTOFF_IN,
    // Relays and lamps
    output logic                        RUN_RELAY_OUT,
    output logic                        FINAL_PHASE_RELAY_OUT,
    output logic                        START_LAMP_OUT,
    output logic                        ARM_LAMP_OUT,
    // Slide commands
    output logic                        SLIDE_MANUAL_OUT,
    output logic                        SLIDE_HOLD_OUT,
    output logic                        VERT_UP_OUT,
    output logic                        HORIZ_RIGHT_OUT,
    // Status
    output logic                        CYCLE_DONE_OUT,
    output logic      [`WCS_TIME_W-1:0] DISPLAY_OUT,
    output logic      [3:0]             PHASE_OUT
);

    // Last divider count of one second
    localparam logic [`WCS_DIV_W-1:0] DIV_LAST = `WCS_DIV_W'(TICK_CYCLES - 1);

    wcs_state_t st_r;    // Registered state
    wcs_state_t st_nxt;  // Next state
    wcs_bus_t   bus;     // Bus request bundle

    // Bundle the bus pins
    assign bus = '{addr: ADDR_IN, wdata: WR_DATA_IN, wr: WR_IN, rd: RD_IN};

    // Next-state logic: registers, phase sequence and commands
    always_comb begin
        logic                   tick;       // One-second enable pulse
        logic                   tack_off;   // Tack detection disabled
        logic                   tack_rise;  // New tack or bead edge
        logic                   start_req;  // Cycle start request
        logic                   advance;    // Phase changes this cycle
        logic [`WCS_TIME_W-1:0] secs_inc;   // Elapsed seconds incremented
        logic                   done_set;   // Cycle completion event
        tick      = 1'b0;
        tack_off  = 1'b0;
        tack_rise = 1'b0;
        start_req = 1'b0;
        advance   = 1'b0;
        secs_inc  = '0;
        done_set  = 1'b0;
        st_nxt    = st_r;

        // Shared second tick, restarted at each phase entry
        tick = (st_r.div == DIV_LAST);
        if (tick) begin
            st_nxt.div = '0;
        end else begin
            st_nxt.div = st_r.div + `WCS_DIV_W'(1);
        end
        // Elapsed seconds saturate rather than wrap
        secs_inc = (st_r.secs == '1) ? st_r.secs : st_r.secs + `WCS_TIME_W'(1);
        if (tick) begin
            st_nxt.secs = secs_inc;
        end

        // Either the remote pin or software may disable tack detection in weld time; seek still takes tacks
        tack_off       = TACK_DISABLE_IN | st_r.tack_dis_sw;
        tack_rise      = TACK_IN & ~st_r.tack_q;
        st_nxt.tack_q  = TACK_IN;
        // Start needs automatic mode and a sidetrack direction
        start_req      = (START_IN | st_r.sw_start) & AUTO_IN & SIDETRACK_SEL_IN;
        st_nxt.sw_start = 1'b0;

        // Phase sequence
        unique case (st_r.phase)
            WCS_IDLE: begin
                if (start_req) begin
                    st_nxt.phase = WCS_NULL;
                    advance      = 1'b1;
                end
            end
            WCS_NULL: begin
                // Relay waits for every cooperating system
                if (ALL_NULL_IN) begin
                    st_nxt.phase = WCS_LOCKOUT;
                    advance      = 1'b1;
                end
            end
            WCS_LOCKOUT: begin
                if (tick && secs_inc >= `WCS_LOCKOUT_S) begin
                    st_nxt.phase = WCS_WELD;
                    advance      = 1'b1;
                end
            end
            WCS_WELD: begin
                // Cut-off acts like the weld timer running out
                if (CUTOFF_IN) begin
                    st_nxt.phase = WCS_SEEK;
                    advance      = 1'b1;
                end else if (st_r.weld_time == '0 ||
                             (tick && secs_inc >= st_r.weld_time)) begin
                    st_nxt.phase = WCS_SEEK;
                    advance      = 1'b1;
                end
            end
            WCS_SEEK: begin
                // Edge only, so a tack still present at expiry is not the next one
                if (tack_rise) begin
                    st_nxt.phase = WCS_OVERLAP;
                    advance      = 1'b1;
                end
            end
            WCS_OVERLAP: begin
                if (st_r.overlap_time == '0 ||
                    (tick && secs_inc >= st_r.overlap_time)) begin
                    st_nxt.phase = WCS_FINAL;
                    advance      = 1'b1;
                end
            end
            WCS_FINAL: begin
                if (st_r.final_time == '0 ||
                    (tick && secs_inc >= st_r.final_time)) begin
                    st_nxt.phase = WCS_CRATER;
                    advance      = 1'b1;
                end
            end
            WCS_CRATER: begin
                if (tick && secs_inc >= `WCS_CRATER_S) begin
                    st_nxt.phase = WCS_RETRACT;
                    advance      = 1'b1;
                end
            end
            WCS_RETRACT: begin
                if (st_r.retract_time == '0 ||
                    (tick && secs_inc >= st_r.retract_time)) begin
                    st_nxt.phase = WCS_IDLE;
                    advance      = 1'b1;
                    done_set     = 1'b1;
                end
            end
            default: begin
                // Illegal code recovers to idle
                st_nxt.phase = WCS_IDLE;
                advance      = 1'b1;
            end
        endcase

        // Fresh phase starts a whole second and zero elapsed
        if (advance) begin
            st_nxt.div  = '0;
            st_nxt.secs = '0;
        end

        // Software register writes
        if (bus.wr) begin
            unique case (bus.addr)
                `WCS_CTRL_OFS: begin
                    st_nxt.tack_dis_sw = bus.wdata[`WCS_CTRL_TACK_DIS];
                    st_nxt.sw_start    = bus.wdata[`WCS_CTRL_SW_START];
                end
                `WCS_WELD_OFS:    st_nxt.weld_time    = bus.wdata[`WCS_TIME_W-1:0];
                `WCS_OVERLAP_OFS: st_nxt.overlap_time = bus.wdata[`WCS_TIME_W-1:0];
                `WCS_FINAL_OFS:   st_nxt.final_time   = bus.wdata[`WCS_TIME_W-1:0];
                `WCS_RETRACT_OFS: st_nxt.retract_time = bus.wdata[`WCS_TIME_W-1:0];
                `WCS_STATUS_OFS: begin
                    // Write one clears the done flag
                    if (bus.wdata[`WCS_STAT_DONE]) begin
                        st_nxt.done_flag = 1'b0;
                    end
                end
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
        // A completion in the clearing cycle still sets the flag
        if (done_set) begin
            st_nxt.done_flag = 1'b1;
        end

        // Read data for the next cycle only
        st_nxt.rdata = '0;
        if (bus.rd) begin
            unique case (bus.addr)
                `WCS_CTRL_OFS: begin
                    st_nxt.rdata[`WCS_CTRL_TACK_DIS] = st_r.tack_dis_sw;
                end
                `WCS_WELD_OFS:    st_nxt.rdata[`WCS_TIME_W-1:0] = st_r.weld_time;
                `WCS_OVERLAP_OFS: st_nxt.rdata[`WCS_TIME_W-1:0] = st_r.overlap_time;
                `WCS_FINAL_OFS:   st_nxt.rdata[`WCS_TIME_W-1:0] = st_r.final_time;
                `WCS_RETRACT_OFS: st_nxt.rdata[`WCS_TIME_W-1:0] = st_r.retract_time;
                `WCS_STATUS_OFS: begin
                    st_nxt.rdata[`WCS_STAT_DONE]     = st_r.done_flag;
                    st_nxt.rdata[`WCS_STAT_TACK_DIS] = tack_off;
                    st_nxt.rdata[`WCS_STAT_STATE_HI:`WCS_STAT_STATE_LO] = st_r.phase;
                end
                `WCS_DISPLAY_OFS: st_nxt.rdata[`WCS_TIME_W-1:0] = st_r.display;
                default: begin
                    // Unmapped address reads zero
                end
            endcase
        end

        // Commands follow the phase being entered, so outputs stay registered
        st_nxt.cmd = '0;
        unique case (st_nxt.phase)
            WCS_IDLE: begin
                st_nxt.cmd.slide_manual = 1'b1;
            end
            WCS_NULL: begin
                // Still tracking while the others find their seams
            end
            WCS_LOCKOUT: begin
                st_nxt.cmd.run_relay    = 1'b1;
                st_nxt.cmd.start_lamp   = 1'b1;
                st_nxt.cmd.slide_manual = 1'b1;
            end
            WCS_WELD: begin
                st_nxt.cmd.run_relay    = 1'b1;
                st_nxt.cmd.start_lamp   = 1'b1;
                st_nxt.cmd.arm_lamp     = ~tack_off;
                // Manual only while an enabled tack is under the sensor
                st_nxt.cmd.slide_manual = TACK_IN & ~tack_off;
            end
            WCS_SEEK: begin
                st_nxt.cmd.run_relay  = 1'b1;
                st_nxt.cmd.start_lamp = 1'b1;
            end
            WCS_OVERLAP: begin
                st_nxt.cmd.run_relay    = 1'b1;
                st_nxt.cmd.start_lamp   = 1'b1;
                st_nxt.cmd.slide_manual = 1'b1;
            end
            WCS_FINAL: begin
                st_nxt.cmd.run_relay         = 1'b1;
                st_nxt.cmd.start_lamp        = 1'b1;
                st_nxt.cmd.final_phase_relay = 1'b1;
                st_nxt.cmd.slide_manual      = 1'b1;
            end
            WCS_CRATER: begin
                // Relays drop; slides frozen where they stand
                st_nxt.cmd.slide_manual = 1'b1;
                st_nxt.cmd.slide_hold   = 1'b1;
            end
            WCS_RETRACT: begin
                st_nxt.cmd.slide_manual = 1'b1;
                st_nxt.cmd.vert_up      = 1'b1;
                // Horizontal waits so the sensor clears the work first
                st_nxt.cmd.horiz_right  = (st_nxt.secs >= `WCS_HRETRACT_S);
            end
            default: begin
                st_nxt.cmd.slide_manual = 1'b1;
            end
        endcase
        st_nxt.cmd.cycle_done = done_set;

        // Display shows remaining weld seconds during weld time
        if (st_nxt.phase == WCS_WELD) begin
            st_nxt.display = (st_nxt.secs >= st_r.weld_time) ? '0
                           : st_r.weld_time - st_nxt.secs;
        end else begin
            st_nxt.display = '0;
        end
    end

    // State register with synchronous reset to idle
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            st_r              <= '0;
            st_r.phase        <= WCS_IDLE;
            st_r.weld_time    <= `WCS_WELD_RST;
            st_r.overlap_time <= `WCS_OVERLAP_RST;
            st_r.final_time   <= `WCS_FINAL_RST;
            st_r.retract_time <= `WCS_RETRACT_RST;
            st_r.cmd.slide_manual <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Ports straight from the state register
    assign RD_DATA_OUT           = st_r.rdata;
    assign RUN_RELAY_OUT         = st_r.cmd.run_relay;
    assign FINAL_PHASE_RELAY_OUT = st_r.cmd.final_phase_relay;
    assign START_LAMP_OUT        = st_r.cmd.start_lamp;
    assign ARM_LAMP_OUT          = st_r.cmd.arm_lamp;
    assign SLIDE_MANUAL_OUT      = st_r.cmd.slide_manual;
    assign SLIDE_HOLD_OUT        = st_r.cmd.slide_hold;
    assign VERT_UP_OUT           = st_r.cmd.vert_up;
    assign HORIZ_RIGHT_OUT       = st_r.cmd.horiz_right;
    assign CYCLE_DONE_OUT        = st_r.cmd.cycle_done;
    assign DISPLAY_OUT           = st_r.display;
    assign PHASE_OUT             = st_r.phase;

endmodule
`default_nettype wire

// ===== include/wcseq_map.svh
// Offsets, field positions, reset values and timing counts of the weld cycle sequencer
`ifndef WCSEQ_MAP_SVH
`define WCSEQ_MAP_SVH

// Register bus widths
`define WCS_ADDR_W          8
`define WCS_DATA_W          32
`define WCS_TIME_W          16

// Register byte offsets
`define WCS_CTRL_OFS        8'h00
`define WCS_WELD_OFS        8'h04
`define WCS_OVERLAP_OFS     8'h08
`define WCS_FINAL_OFS       8'h0C
`define WCS_RETRACT_OFS     8'h10
`define WCS_STATUS_OFS      8'h14
`define WCS_DISPLAY_OFS     8'h18

// Control register fields
`define WCS_CTRL_TACK_DIS   0
`define WCS_CTRL_SW_START   1

// Status register fields
`define WCS_STAT_DONE       0
`define WCS_STAT_TACK_DIS   1
`define WCS_STAT_STATE_LO   4
`define WCS_STAT_STATE_HI   7

// Reset values of the phase timers, in seconds
`define WCS_WELD_RST        16'h003C
`define WCS_OVERLAP_RST     16'h0005
`define WCS_FINAL_RST       16'h0004
`define WCS_RETRACT_RST     16'h0004

// Fixed delays, in seconds
`define WCS_LOCKOUT_S       16'h0002
`define WCS_CRATER_S        16'h0002
`define WCS_HRETRACT_S      16'h0002

// Tick timing
`define WCS_CLK_PERIOD_NS   10
`define WCS_TICK_PERIOD_NS  1000000000
`define WCS_TICK_CYCLES     (`WCS_TICK_PERIOD_NS / `WCS_CLK_PERIOD_NS)
`define WCS_DIV_W           27

`endif

// ===== include/wcseq_pkg.sv
// Types of the weld cycle sequencer
`include "wcseq_map.svh"

package wcseq_pkg;

    // Phases of one weld cycle
    typedef enum logic [3:0] {
        WCS_IDLE     = 4'h0,
        WCS_NULL     = 4'h1,
        WCS_LOCKOUT  = 4'h2,
        WCS_WELD     = 4'h3,
        WCS_SEEK     = 4'h4,
        WCS_OVERLAP  = 4'h5,
        WCS_FINAL    = 4'h6,
        WCS_CRATER   = 4'h7,
        WCS_RETRACT  = 4'h8
    } wcs_phase_t;

    // Software bus request
    typedef struct packed {
        logic [`WCS_ADDR_W-1:0] addr;
        logic [`WCS_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } wcs_bus_t;

    // Relay, lamp and slide commands
    typedef struct packed {
        logic run_relay;
        logic final_phase_relay;
        logic start_lamp;
        logic arm_lamp;
        logic slide_manual;
        logic slide_hold;
        logic vert_up;
        logic horiz_right;
        logic cycle_done;
    } wcs_cmd_t;

    // Whole state of the sequencer
    typedef struct packed {
        wcs_phase_t             phase;
        logic [`WCS_DIV_W-1:0]  div;
        logic [`WCS_TIME_W-1:0] secs;
        logic                   tack_q;
        logic                   tack_dis_sw;
        logic                   sw_start;
        logic                   done_flag;
        logic [`WCS_TIME_W-1:0] weld_time;
        logic [`WCS_TIME_W-1:0] overlap_time;
        logic [`WCS_TIME_W-1:0] final_time;
        logic [`WCS_TIME_W-1:0] retract_time;
        logic [`WCS_TIME_W-1:0] display;
        wcs_cmd_t               cmd;
        logic [`WCS_DATA_W-1:0] rdata;
    } wcs_state_t;

endpackage

// ===== verif/wcseq_assertions.sv
// Port-level assertions of the weld cycle sequencer, with their bind
`timescale 1ns/10ps
`default_nettype none
`include "wcseq_map.svh"
module wcseq_checker
    import wcseq_pkg::*;
#(
    parameter int TICK_CYCLES = 4   // Cycles per second tick
) (
    // Clock, reset and pins
    input  wire logic             CLK_IN,
    input  wire logic             RST_IN,
    input  wire logic             ALL_NULL_IN,
    input  wire logic             TACK_IN,
    input  wire logic             CUTOFF_IN,
    // Outputs watched
    input  wire logic             RUN_RELAY_OUT,
    input  wire logic             FINAL_PHASE_RELAY_OUT,
    input  wire logic             START_LAMP_OUT,
    input  wire logic             SLIDE_MANUAL_OUT,
    input  wire logic             SLIDE_HOLD_OUT,
    input  wire logic             VERT_UP_OUT,
    input  wire logic             HORIZ_RIGHT_OUT,
    input  wire logic             CYCLE_DONE_OUT,
    input  wire logic [3:0]       PHASE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    logic [3:0]  ph_q;                      // Phase one cycle back
    logic [15:0] len_r;                     // Cycles the old phase stood
    wire         moved = PHASE_OUT != ph_q; // Phase changed this cycle
    // Length counter restarts at each change, so exit checks see full stays
    always_ff @(posedge CLK_IN) begin
        ph_q  <= PHASE_OUT;
        len_r <= RST_IN ? 16'h0000 : (moved ? 16'h0001 : len_r + 16'h0001);
    end
    chk_null_wait:
        assert property (PHASE_OUT == WCS_NULL && !ALL_NULL_IN |=> PHASE_OUT == WCS_NULL
            && !RUN_RELAY_OUT) else $error("null wait left early");
    chk_lamp_relay:
        assert property (START_LAMP_OUT == RUN_RELAY_OUT) else $error("start lamp off relay");
    chk_lockout_len:
        assert property (moved && ph_q == WCS_LOCKOUT |-> len_r == 2 * TICK_CYCLES
            && PHASE_OUT == WCS_WELD) else $error("lockout length wrong");
    chk_weld_entry:
        assert property (moved && PHASE_OUT == WCS_WELD && !$past(TACK_IN) |->
            !SLIDE_MANUAL_OUT && RUN_RELAY_OUT) else $error("weld entry not tracking");
    chk_cutoff_end:
        assert property (PHASE_OUT == WCS_WELD && CUTOFF_IN |=> PHASE_OUT == WCS_SEEK)
            else $error("cut-off ignored");
    chk_seek_stay:
        assert property (PHASE_OUT == WCS_SEEK && !TACK_IN |=> PHASE_OUT == WCS_SEEK)
            else $error("seek left without tack");
    chk_seek_tack:
        assert property (PHASE_OUT == WCS_SEEK && $rose(TACK_IN) |=> PHASE_OUT == WCS_OVERLAP)
            else $error("tack did not start overlap");
    chk_overlap_mode:
        assert property (PHASE_OUT == WCS_OVERLAP |-> SLIDE_MANUAL_OUT && RUN_RELAY_OUT)
            else $error("overlap outputs wrong");
    chk_final_relay:
        assert property (FINAL_PHASE_RELAY_OUT == (PHASE_OUT == WCS_FINAL))
            else $error("final relay outside final phase");
    chk_crater_hold:
        assert property (PHASE_OUT == WCS_CRATER |-> !RUN_RELAY_OUT && !FINAL_PHASE_RELAY_OUT
            && SLIDE_MANUAL_OUT && SLIDE_HOLD_OUT) else $error("crater outputs wrong");
    chk_crater_len:
        assert property (moved && ph_q == WCS_CRATER |-> len_r == 2 * TICK_CYCLES
            && PHASE_OUT == WCS_RETRACT) else $error("crater length wrong");
    chk_retract_up:
        assert property (moved && PHASE_OUT == WCS_RETRACT |-> VERT_UP_OUT && !HORIZ_RIGHT_OUT)
            else $error("retract entry wrong");
    chk_horiz_delay:
        assert property ($rose(HORIZ_RIGHT_OUT) |-> PHASE_OUT == WCS_RETRACT
            && len_r == 2 * TICK_CYCLES) else $error("horizontal retract early or late");
    chk_done_pulse:
        assert property (CYCLE_DONE_OUT |-> PHASE_OUT == WCS_IDLE && ph_q == WCS_RETRACT
            ##1 !CYCLE_DONE_OUT) else $error("done pulse wrong");
    cover property (moved && PHASE_OUT == WCS_OVERLAP);
    cover property (PHASE_OUT == WCS_WELD && CUTOFF_IN);
    cover property (CYCLE_DONE_OUT);
endmodule
bind wcseq_top wcseq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .CLK_IN(CLK_IN), .RST_IN(RST_IN), .ALL_NULL_IN(ALL_NULL_IN), .TACK_IN(TACK_IN),
    .CUTOFF_IN(CUTOFF_IN), .RUN_RELAY_OUT(RUN_RELAY_OUT),
    .FINAL_PHASE_RELAY_OUT(FINAL_PHASE_RELAY_OUT), .START_LAMP_OUT(START_LAMP_OUT),
    .SLIDE_MANUAL_OUT(SLIDE_MANUAL_OUT), .SLIDE_HOLD_OUT(SLIDE_HOLD_OUT),
    .VERT_UP_OUT(VERT_UP_OUT), .HORIZ_RIGHT_OUT(HORIZ_RIGHT_OUT),
    .CYCLE_DONE_OUT(CYCLE_DONE_OUT), .PHASE_OUT(PHASE_OUT));
`default_nettype wire

// ===== verif/wcseq_pendant_model.sv
// Model of the pendant, remote inputs and cooperating trackers
`timescale 1ns/10ps
`default_nettype none
module wcseq_pendant_model (
    // Clock
    input  wire logic clk_in,
    // Pins toward the sequencer
    output logic      start_out,
    output logic      auto_out,
    output logic      side_out,
    output logic      null_out,
    output logic      tack_out,
    output logic      tack_dis_out,
    output logic      cutoff_out
);
    // Everything quiet until the bench acts
    initial begin
        {start_out, auto_out, side_out, null_out} = 4'h0;
        {tack_out, tack_dis_out, cutoff_out} = 3'h0;
    end
    // Start push; the other trackers lose null when a cycle begins
    task automatic press_start(input logic auto_v, input logic side_v);
        @(posedge clk_in);
        auto_out  <= auto_v;
        side_out  <= side_v;
        start_out <= 1'b1;
        null_out  <= 1'b0;
        @(posedge clk_in);
        start_out <= 1'b0;
    endtask
    // Level on a remote line: 0 tack, 1 tack disable, 2 cut-off, else null
    task automatic set_pin(input int which, input logic v);
        @(posedge clk_in);
        case (which)
            0: tack_out <= v;
            1: tack_dis_out <= v;
            2: cutoff_out <= v;
            default: null_out <= v;
        endcase
    endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the weld cycle sequencer
`timescale 1ns/10ps
`default_nettype none
`include "wcseq_map.svh"
module testbench
    import wcseq_pkg::*;
;
    localparam int TK = 4;      // Short tick keeps the run brief
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        start, auto_v, side, nul, tack, tdis, cut;
    logic        run, fin, slamp, alamp, man, hold, vup, hr, done;
    logic [15:0] disp;
    logic [3:0]  ph;
    int          bad_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    wire  [31:0] outs = {23'h0, run, fin, slamp, alamp, man, hold, vup, hr, done};
    wire  [31:0] phw = {28'h0, ph};
    wcseq_top #(.TICK_CYCLES(TK)) dut_u (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .WR_DATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdata), .START_IN(start),
        .AUTO_IN(auto_v), .SIDETRACK_SEL_IN(side), .ALL_NULL_IN(nul), .TACK_IN(tack),
        .TACK_DISABLE_IN(tdis), .CUTOFF_IN(cut), .RUN_RELAY_OUT(run),
        .FINAL_PHASE_RELAY_OUT(fin), .START_LAMP_OUT(slamp), .ARM_LAMP_OUT(alamp),
        .SLIDE_MANUAL_OUT(man), .SLIDE_HOLD_OUT(hold), .VERT_UP_OUT(vup),
        .HORIZ_RIGHT_OUT(hr), .CYCLE_DONE_OUT(done), .DISPLAY_OUT(disp), .PHASE_OUT(ph));
    wcseq_pendant_model pm_u (.clk_in(clk), .start_out(start), .auto_out(auto_v),
        .side_out(side), .null_out(nul), .tack_out(tack), .tack_dis_out(tdis),
        .cutoff_out(cut));
    // Clock and a hang guard well above the few hundred cycles needed
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        check(what, exp, rdata);
    endtask
    // Bounded wait; n holds the cycles spent
    task automatic wait_ph(input wcs_phase_t p);
        n = 0;
        while (phw !== {28'h0, p} && n < 400) begin
            @(negedge clk);
            n++;
        end
        // A wait that runs out counts as a mismatch
        if (n == 400) check("phase wait", {28'h0, p}, phw);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("idle outputs", 32'h010, outs);
        rd_reg(`WCS_WELD_OFS, {16'h0, `WCS_WELD_RST}, "weld reset");
        rd_reg(`WCS_RETRACT_OFS, {16'h0, `WCS_RETRACT_RST}, "retract reset");
        wr_reg(8'h1C, 32'hFFFF);
        rd_reg(8'h1C, 32'h0, "unmapped");
        wr_reg(`WCS_WELD_OFS, 32'h1);
        wr_reg(`WCS_OVERLAP_OFS, 32'h1);
        wr_reg(`WCS_FINAL_OFS, 32'h1);
        wr_reg(`WCS_RETRACT_OFS, 32'h3);
        pm_u.press_start(1'b0, 1'b1);
        pm_u.press_start(1'b1, 1'b0);
        repeat (3) @(negedge clk);
        check("start without auto", 32'h0, phw);
        pm_u.press_start(1'b1, 1'b1);
        wait_ph(WCS_NULL);
        repeat (6) @(negedge clk);
        check("null wait", 32'h000, outs);
        pm_u.set_pin(4, 1'b1);
        wait_ph(WCS_LOCKOUT);
        check("lockout outputs", 32'h150, outs);
        wait_ph(WCS_WELD);
        check("lockout cycles", 2 * TK, n);
        check("weld outputs", 32'h160, outs);
        check("display", 32'h1, {16'h0, disp});
        wait_ph(WCS_SEEK);
        check("weld cycles", TK, n);
        repeat (5) @(negedge clk);
        check("seek holds", {28'h0, WCS_SEEK}, phw);
        pm_u.set_pin(0, 1'b1);
        wait_ph(WCS_OVERLAP);
        check("tack to overlap", 2, n);
        check("overlap outputs", 32'h150, outs);
        pm_u.set_pin(0, 1'b0);
        wait_ph(WCS_FINAL);
        check("final relays", 32'h7, {29'h0, outs[8:6]});
        wait_ph(WCS_CRATER);
        check("final cycles", TK, n);
        check("crater outputs", 32'h018, outs);
        wait_ph(WCS_RETRACT);
        check("crater cycles", 2 * TK, n);
        check("vertical up", 32'h2, {30'h0, outs[2:1]});
        repeat (2 * TK) @(negedge clk);
        check("horizontal right", 32'h3, {30'h0, outs[2:1]});
        wait_ph(WCS_IDLE);
        check("retract rest", TK, n);
        check("done outputs", 32'h011, outs);
        rd_reg(`WCS_STATUS_OFS, 32'h1, "done flag");
        wr_reg(`WCS_STATUS_OFS, 32'h1);
        wr_reg(`WCS_WELD_OFS, 32'hA);
        wr_reg(`WCS_RETRACT_OFS, 32'h1);
        wr_reg(`WCS_CTRL_OFS, 32'h2);
        wait_ph(WCS_WELD);
        pm_u.set_pin(0, 1'b1);
        repeat (2) @(negedge clk);
        check("tack manual", 32'h1, {31'h0, man});
        pm_u.set_pin(0, 1'b0);
        repeat (2) @(negedge clk);
        check("tack passed", 32'h0, {31'h0, man});
        pm_u.set_pin(1, 1'b1);
        pm_u.set_pin(0, 1'b1);
        repeat (2) @(negedge clk);
        check("disabled tack", 32'h0, {30'h0, outs[5:4]});
        rd_reg(`WCS_STATUS_OFS, 32'h32, "status disable");
        pm_u.set_pin(0, 1'b0);
        pm_u.set_pin(2, 1'b1);
        wait_ph(WCS_SEEK);
        check("cut-off delay", 2, n);
        pm_u.set_pin(2, 1'b0);
        pm_u.set_pin(0, 1'b1);
        wait_ph(WCS_OVERLAP);
        check("tack while disabled", 2, n);
        pm_u.set_pin(1, 1'b0);
        pm_u.set_pin(0, 1'b0);
        wait_ph(WCS_RETRACT);
        wait_ph(WCS_IDLE);
        check("short retract", TK, n);
        pm_u.press_start(1'b1, 1'b1);
        pm_u.set_pin(4, 1'b1);
        wait_ph(WCS_LOCKOUT);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("reset outputs", 32'h010, outs);
        check("reset phase", 32'h0, phw);
        complete_run();
    end
endmodule
`default_nettype wire
